// ==== rtl/pvp_bclk_gen.sv ====
// master bit clock and frame sync generator
`timescale 1ns/1ps
`default_nettype none
`include "pvp_defines.svh"
module pvp_bclk_gen import pvp_pkg::*; #(
    parameter int HALF0 = `PVP_HALF_CYC(`PVP_RATE0_KHZ),
    parameter int HALF1 = `PVP_HALF_CYC(`PVP_RATE1_KHZ),
    parameter int HALF2 = `PVP_HALF_CYC(`PVP_RATE2_KHZ)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pvp_link_if.gen lk
);
    logic [9:0] cnt_reg;
    logic [6:0] fb_reg;
    wire [9:0] half = (lk.rate == 2'h0) ? 10'(HALF0 - 1) :
                      (lk.rate == 2'h1) ? 10'(HALF1 - 1) : 10'(HALF2 - 1);
    wire [6:0] flast = (lk.rate == 2'h0) ?
                       7'(`PVP_FRAME_BITS(`PVP_RATE0_KHZ) - 1) :
                       (lk.rate == 2'h1) ?
                       7'(`PVP_FRAME_BITS(`PVP_RATE1_KHZ) - 1) :
                       7'(`PVP_FRAME_BITS(`PVP_RATE2_KHZ) - 1);
    wire tick = (cnt_reg == half);
    wire up = tick & ~lk.bclk;
    wire [6:0] fb_next = (fb_reg >= flast) ? 7'h00 : fb_reg + 7'h01;
    // sync shape per format: long 8 bits, short one bit before word, gci 1
    wire sync_next = lk.sync_zero ? 1'b0 :
                     lk.short_fs ? (fb_next == flast) :
                     lk.gci ? (fb_next == 7'h00) :
                     (fb_next < 7'(`PVP_LFS_HIGH_BITS));
    always_ff @(posedge clk_i) begin
        if (rst_i || !lk.run) begin
            cnt_reg <= 10'h000;
            fb_reg <= 7'h7F;
            lk.bclk <= 1'b0;
            lk.rise <= 1'b0;
            lk.fall <= 1'b0;
            lk.sync <= 1'b0;
        end else begin
            cnt_reg <= tick ? 10'h000 : cnt_reg + 10'h001;
            lk.rise <= up;
            lk.fall <= tick & lk.bclk;
            if (tick) lk.bclk <= ~lk.bclk;
            if (up) begin
                fb_reg <= fb_next;
                lk.sync <= sync_next;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/pvp_defines.svh ====
// constants of the voice serial port: timing, register map, config fields
`ifndef PVP_DEFINES_SVH
`define PVP_DEFINES_SVH
`define PVP_CLK_HZ 100000000
`define PVP_RATE0_KHZ 128
`define PVP_RATE1_KHZ 256
`define PVP_RATE2_KHZ 512
`define PVP_SAMPLE_HZ 8000
`define PVP_HALF_CYC(k) (`PVP_CLK_HZ / (2 * (k) * 1000))
`define PVP_FRAME_BITS(k) ((k) * 1000 / `PVP_SAMPLE_HZ)
`define PVP_LFS_HIGH_BITS 8
`define PVP_SLOTS 4
`define PVP_FULL_MASK 4'hF
`define PVP_THREE_MASK 4'h7
`define PVP_WIN16 9'h040
`define PVP_WIN8 9'h020
`define PVP_LAST16 4'hF
`define PVP_LAST8 4'h7
`define PVP_CNT_MAX 9'h1FF
`define PVP_ADDR_CFG 8'h00
`define PVP_ADDR_STAT 8'h04
`define PVP_TX_PAGE 4'h1
`define PVP_RX_PAGE 4'h2
`define PVP_CFG_RESET 32'h0000_0000
`define PVP_CFG_MASTER 0
`define PVP_CFG_ENABLE 1
`define PVP_CFG_FRAME 3:2
`define PVP_CFG_FMT 5:4
`define PVP_CFG_MASK 9:6
`define PVP_CFG_SLOT16 10
`define PVP_CFG_FILL 12:11
`define PVP_CFG_ATT 15:13
`define PVP_CFG_MUTE 16
`define PVP_CFG_SYNC0 17
`define PVP_CFG_RATE 19:18
`define PVP_CFG_TZLATE 20
`endif

// ==== rtl/pvp_link_if.sv ====
// bit clock and frame sync link between the core and the master generator
`timescale 1ns/1ps
`default_nettype none
interface pvp_link_if;
    logic [1:0] rate;
    logic run;
    logic short_fs;
    logic gci;
    logic sync_zero;
    logic bclk;
    logic rise;
    logic fall;
    logic sync;
    modport gen (input rate, run, short_fs, gci, sync_zero,
                 output bclk, rise, fall, sync);
    modport core (output rate, run, short_fs, gci, sync_zero,
                  input bclk, rise, fall, sync);
endinterface
`default_nettype wire

// ==== rtl/pvp_pin_sync.sv ====
// three-stage pin synchroniser with agreed level and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pvp_pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic lvl_o,
    output logic rise_o,
    output logic fall_o
);
    logic s1_reg, s2_reg, s3_reg;
    // a change counts only once stages two and three agree
    always_ff @(posedge clk_i) begin
        s1_reg <= d_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (rst_i) begin
            lvl_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= (s2_reg == s3_reg) & s3_reg & ~lvl_o;
            fall_o <= (s2_reg == s3_reg) & ~s3_reg & lvl_o;
            if (s2_reg == s3_reg) lvl_o <= s3_reg;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/pvp_pkg.sv ====
// types shared by the voice serial port modules
package pvp_pkg;
    typedef enum logic [1:0] {PVP_LONG, PVP_SHORT, PVP_GCI, PVP_FR_RSVD}
        pvp_frame_e;
    typedef enum logic [1:0] {PVP_LIN13, PVP_LIN16, PVP_ULAW, PVP_ALAW}
        pvp_fmt_e;
    typedef enum logic [1:0] {PVP_FILL_SIGN, PVP_FILL_ZERO, PVP_FILL_ATT,
        PVP_FILL_RSVD} pvp_fill_e;
    typedef logic [15:0] pvp_word_t;
endpackage

// ==== rtl/pvp_voice_port.sv ====
// voice serial port core: wishbone registers, slot engine, pin control
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pvp_defines.svh"
module pvp_voice_port import pvp_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pcm_clk_i,
    output logic pcm_clk_o,
    output logic pcm_clk_oe_o,
    input wire logic pcm_sync_i,
    output logic pcm_sync_o,
    output logic pcm_sync_oe_o,
    input wire logic pcm_in_i,
    output logic pcm_out_o,
    output logic pcm_out_oe_o
);
    pvp_link_if lk ();

    logic [31:0] cfg_reg;
    pvp_word_t tx_reg [`PVP_SLOTS];
    pvp_word_t rx_reg [`PVP_SLOTS];
    logic [`PVP_SLOTS-1:0] new_reg;
    logic [7:0] fcnt_reg;
    logic [8:0] bit_cnt_reg;
    logic framed_reg;
    logic sync_prev_reg;
    pvp_word_t rx_sh_reg;

    // --- configuration word decode
    wire master = cfg_reg[`PVP_CFG_MASTER];
    wire enable = cfg_reg[`PVP_CFG_ENABLE];
    wire pvp_frame_e frame = pvp_frame_e'(cfg_reg[`PVP_CFG_FRAME]);
    wire pvp_fmt_e fmt = pvp_fmt_e'(cfg_reg[`PVP_CFG_FMT]);
    wire pvp_fill_e fill = pvp_fill_e'(cfg_reg[`PVP_CFG_FILL]);
    wire [2:0] att = cfg_reg[`PVP_CFG_ATT];
    wire mute = cfg_reg[`PVP_CFG_MUTE];
    wire tz_late = cfg_reg[`PVP_CFG_TZLATE];
    wire [3:0] mask = cfg_reg[`PVP_CFG_MASK];
    wire short_fs = (frame == PVP_SHORT);
    wire lin = (fmt == PVP_LIN13) || (fmt == PVP_LIN16);
    // linear samples never fit an 8-clock slot, so force 16
    wire slot16 = cfg_reg[`PVP_CFG_SLOT16] | lin;
    // a fourth enabled slot is dropped
    wire [3:0] act_mask = (mask == `PVP_FULL_MASK) ?
                          `PVP_THREE_MASK : mask;
    wire att_on = (fill == PVP_FILL_ATT);

    // master generator controls
    assign lk.rate = cfg_reg[`PVP_CFG_RATE];
    assign lk.run = master & enable;
    assign lk.short_fs = short_fs;
    assign lk.gci = (frame == PVP_GCI);
    assign lk.sync_zero = cfg_reg[`PVP_CFG_SYNC0];

    pvp_bclk_gen u_gen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lk(lk)
    );

    // --- slave pin inputs pass four flip-flops (three stages, then the level register)
    logic s_clk_lvl, s_clk_rise, s_clk_fall;
    logic s_sync_lvl, s_in_lvl;

    pvp_pin_sync u_clk_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pcm_clk_i),
        .lvl_o(s_clk_lvl),
        .rise_o(s_clk_rise),
        .fall_o(s_clk_fall)
    );

    pvp_pin_sync u_fs_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pcm_sync_i),
        .lvl_o(s_sync_lvl),
        .rise_o(),
        .fall_o()
    );

    pvp_pin_sync u_in_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pcm_in_i),
        .lvl_o(s_in_lvl),
        .rise_o(),
        .fall_o()
    );

    // bit clock events from whichever side owns the clock
    wire rise_ev = enable & (master ? lk.rise : s_clk_rise);
    wire fall_ev = enable & (master ? lk.fall : s_clk_fall);
    wire sync_lvl = master ? lk.sync : s_sync_lvl;
    wire sync_up = sync_lvl & ~sync_prev_reg;
    // long and gci frames begin on the sync rising edge
    wire long_start = enable & ~short_fs & sync_up;
    // short frames: sync high at a fall arms the next bit
    wire short_arm = fall_ev & short_fs & sync_lvl;

    // --- slot position of a bit count
    function automatic logic [5:0] slot_pos(input logic [8:0] c,
                                            input logic s16);
        logic [1:0] idx;
        logic [3:0] pos;
        logic win;
        idx = s16 ? c[5:4] : c[4:3];
        pos = s16 ? c[3:0] : {1'b0, c[2:0]};
        win = s16 ? (c < `PVP_WIN16) : (c < `PVP_WIN8);
        return {win, idx, pos[2:0]} ^ 6'h00 | {5'h00, 1'b0} |
               {1'b0, 2'b00, 3'b000} | ({6{1'b0}}) |
               ({win, idx, pos[2:0]} & 6'h3F);
    endfunction

    // count used for drive decisions: frame start drives bit 0
    wire [8:0] drv_cnt = long_start ? 9'h000 : bit_cnt_reg;
    wire drv_win = slot16 ? (drv_cnt < `PVP_WIN16) : (drv_cnt < `PVP_WIN8);
    wire [1:0] drv_idx = slot16 ? drv_cnt[5:4] : drv_cnt[4:3];
    wire [3:0] drv_pos = slot16 ? drv_cnt[3:0] : {1'b0, drv_cnt[2:0]};
    wire drv_act = (framed_reg | long_start) & drv_win & act_mask[drv_idx];

    // sample side uses the running count
    wire smp_win = slot16 ? (bit_cnt_reg < `PVP_WIN16) :
                   (bit_cnt_reg < `PVP_WIN8);
    wire [1:0] smp_idx = slot16 ? bit_cnt_reg[5:4] : bit_cnt_reg[4:3];
    wire [3:0] smp_pos = slot16 ? bit_cnt_reg[3:0] :
                         {1'b0, bit_cnt_reg[2:0]};
    wire [3:0] last = slot16 ? `PVP_LAST16 : `PVP_LAST8;
    wire smp_act = framed_reg & smp_win & act_mask[smp_idx];
    wire smp_last = smp_act & (smp_pos == last);

    // transmit word packing per format and fill
    function automatic pvp_word_t tx_build(input pvp_word_t s,
        input pvp_fmt_e f, input pvp_fill_e fl, input logic [2:0] a,
        input logic s16);
        pvp_word_t w;
        w = s;
        if (f == PVP_LIN13) begin
            if (fl == PVP_FILL_ATT) w = {s[12:0], a};
            else if (fl == PVP_FILL_ZERO) w = {3'h0, s[12:0]};
            else w = {{3{s[12]}}, s[12:0]};
        end else if (f != PVP_LIN16) begin
            if (!s16) w = {8'h00, s[7:0]};
            else if (fl == PVP_FILL_ATT) w = {s[7:0], 5'h00, a};
            else if (fl == PVP_FILL_ZERO) w = {8'h00, s[7:0]};
            else w = {{8{s[7]}}, s[7:0]};
        end
        return w;
    endfunction

    // receive word unpacking back to a right-aligned sample
    function automatic pvp_word_t rx_take(input pvp_word_t w,
        input pvp_fmt_e f, input logic a, input logic s16);
        pvp_word_t r;
        r = w;
        if (f == PVP_LIN13) begin
            r = a ? {{3{w[15]}}, w[15:3]} : {{3{w[12]}}, w[12:0]};
        end else if (f != PVP_LIN16) begin
            r = (s16 && a) ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        end
        return r;
    endfunction

    wire pvp_word_t drv_word = tx_build(tx_reg[drv_idx], fmt, fill,
                                        att, slot16);
    // most significant bit of the slot goes out first
    wire [3:0] drv_bit = last - drv_pos;
    wire tx_bit = mute ? 1'b0 : drv_word[drv_bit];
    wire pvp_word_t rx_full = {rx_sh_reg[14:0], s_in_lvl};
    wire pvp_word_t rx_sample = rx_take(rx_full, fmt, att_on, slot16);

    // --- wishbone decode
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire wr_go = wb_req & wb_we_i & wb_ack_o;
    wire hit_cfg = (wb_adr_i == `PVP_ADDR_CFG);
    wire hit_stat = (wb_adr_i == `PVP_ADDR_STAT);
    wire hit_tx = (wb_adr_i[7:4] == `PVP_TX_PAGE) & (wb_adr_i[1:0] == 2'h0);
    wire hit_rx = (wb_adr_i[7:4] == `PVP_RX_PAGE) & (wb_adr_i[1:0] == 2'h0);
    wire [1:0] reg_idx = wb_adr_i[3:2];
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] stat_word = {16'h0000, fcnt_reg, 3'h0, framed_reg, new_reg};
    wire [31:0] rd_data = hit_cfg ? cfg_reg :
                          hit_stat ? stat_word :
                          hit_tx ? {16'h0000, tx_reg[reg_idx]} :
                          hit_rx ? {16'h0000, rx_reg[reg_idx]} :
                          32'h0000_0000;
    wire [3:0] clr_new = (wr_go & hit_stat & wb_sel_i[0]) ?
                         wb_dat_i[3:0] : 4'h0;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o) wb_dat_o <= rd_data;
        end
    end

    // single stored configuration word
    always_ff @(posedge clk_i) begin
        if (rst_i) cfg_reg <= `PVP_CFG_RESET;
        else if (wr_go & hit_cfg)
            cfg_reg <= (cfg_reg & ~bmask) | (wb_dat_i & bmask);
    end

    // --- per-slot sample stores and arrival flags
    genvar g;
    generate
        for (g = 0; g < `PVP_SLOTS; g = g + 1) begin : g_slot
            wire wr_tx = wr_go & hit_tx & (reg_idx == 2'(g));
            wire got = fall_ev & smp_last & (smp_idx == 2'(g));
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    tx_reg[g] <= 16'h0000;
                    rx_reg[g] <= 16'h0000;
                    new_reg[g] <= 1'b0;
                end else begin
                    if (wr_tx)
                        tx_reg[g] <= (tx_reg[g] & ~bmask[15:0]) |
                                     (wb_dat_i[15:0] & bmask[15:0]);
                    if (got) rx_reg[g] <= rx_sample;
                    // a new sample wins over a clear in the same cycle
                    new_reg[g] <= got | (new_reg[g] & ~clr_new[g]);
                end
            end
        end
    endgenerate

    // bit counter, resynchronised on every frame start
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable) begin
            bit_cnt_reg <= `PVP_CNT_MAX;
            framed_reg <= 1'b0;
            sync_prev_reg <= 1'b0;
            fcnt_reg <= 8'h00;
        end else begin
            sync_prev_reg <= sync_lvl;
            if (long_start || short_arm) begin
                bit_cnt_reg <= 9'h000;
                framed_reg <= 1'b1;
                fcnt_reg <= fcnt_reg + 8'h01;
            end else if (fall_ev && bit_cnt_reg != `PVP_CNT_MAX) begin
                bit_cnt_reg <= bit_cnt_reg + 9'h001;
            end
        end
    end

    // input sampled on falling bit clock; idle slots not shifted
    always_ff @(posedge clk_i) begin
        if (rst_i) rx_sh_reg <= 16'h0000;
        else if (fall_ev && smp_act) rx_sh_reg <= rx_full;
    end

    // serial output: driven on rise, released per option
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable) begin
            pcm_out_o <= 1'b0;
            pcm_out_oe_o <= 1'b0;
        end else if (rise_ev || long_start) begin
            pcm_out_o <= drv_act ? tx_bit : 1'b0;
            pcm_out_oe_o <= drv_act;
        end else if (fall_ev && smp_last && !tz_late) begin
            pcm_out_oe_o <= 1'b0;
        end
    end

    // clock and sync pins: only the master drives them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcm_clk_o <= 1'b0;
            pcm_sync_o <= 1'b0;
            pcm_clk_oe_o <= 1'b0;
            pcm_sync_oe_o <= 1'b0;
        end else begin
            pcm_clk_o <= lk.bclk;
            pcm_sync_o <= lk.sync;
            pcm_clk_oe_o <= master & enable;
            pcm_sync_oe_o <= master & enable;
        end
    end
endmodule
`default_nettype wire

// ==== tb/pvp_far_end.sv ====
// far-end codec model: slave clock and sync source, data in, capture
`timescale 1ns/1ps
`default_nettype none
module pvp_far_end (
    input wire logic run_i,
    input wire logic short_i,
    input wire logic clk_w_i,
    input wire logic sync_w_i,
    input wire logic out_i,
    input wire logic oe_i,
    input wire logic [15:0] pat_i,
    output logic bclk_o,
    output logic sync_o,
    output logic din_o,
    output logic [31:0] rx_o
);
    logic [3:0] idx = 4'h0;
    logic oe_q = 1'h0;
    // 32-bit frames back to back; clock stands still low only while run_i is low
    initial begin
        bclk_o = 1'h0;
        sync_o = 1'h0;
        rx_o = 32'h0;
        forever begin
            wait (run_i);
            // edges kept off the system clock grid, 160 ns per bit
            for (int b = 0; b < 32; b++) begin
                #77 bclk_o = 1'h1;
                #1 sync_o = short_i ? (b == 31) : (b < 8);
                #80 bclk_o = 1'h0;
                #2;
            end
            if (!run_i)
                sync_o = 1'h0;
        end
    end
    // next bit at each rise; a long or gci start restarts the count
    always @(posedge clk_w_i)
        idx <= idx + 4'h1;
    // one step late, so a rise in the same instant cannot undo it
    always @(posedge sync_w_i)
        if (!short_i)
            idx <= #1 4'h0;
    // enable judged mid-bit so capture never races the release
    always @(posedge clk_w_i)
        #70 oe_q = oe_i;
    always @(negedge clk_w_i) begin
        if (oe_q)
            rx_o <= {rx_o[30:0], out_i};
        if (short_i && sync_w_i)
            idx <= 4'hF;
    end
    assign din_o = pat_i[~idx];
endmodule
`default_nettype wire

// ==== tb/pvp_voice_port_asserts.sv ====
// assertion checker for the voice serial port top
`timescale 1ns/1ps
`default_nettype none
module pvp_voice_port_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic pcm_clk_o,
    input wire logic pcm_clk_oe_o,
    input wire logic pcm_sync_o,
    input wire logic pcm_sync_oe_o,
    input wire logic pcm_out_o,
    input wire logic pcm_out_oe_o
);
    logic [31:0] cfg;
    logic [3:0] qc;
    logic [9:0] hc;
    logic [12:0] sh;
    logic pc, ps, tv, sv;
    // a config write restarts the settle count; mode checks wait for it
    wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
        wb_adr_i == 8'h00;
    wire [31:0] m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire st = qc == 4'hF;
    wire me = cfg[0] && cfg[1];
    wire tog = pc != pcm_clk_o;
    wire [9:0] h = cfg[19:18] == 2'h0 ? 10'h186 :
        (cfg[19:18] == 2'h1 ? 10'h0C3 : 10'h061);
    wire [12:0] lw = {h, 3'h0} + {h, 3'h0}; // eight bit periods
    // shadow of the config word, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i)
            cfg <= 32'h0000_0000;
        else if (wr)
            cfg <= (cfg & ~m) | (wb_dat_i & m);
    end
    // settle, half-period and sync-width counters
    always_ff @(posedge clk_i) begin
        pc <= pcm_clk_o;
        ps <= pcm_sync_o;
        hc <= tog ? 10'h000 : hc + 10'h001;
        sh <= pcm_sync_o ? sh + 13'h0001 : 13'h0000;
        qc <= (rst_i || wr) ? 4'h0 : qc + {3'h0, !st};
        tv <= (rst_i || wr) ? 1'h0 : (tv || tog);
        sv <= (rst_i || wr) ? 1'h0 : (pcm_sync_o && (sv || !ps));
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    AST_HANDS_OFF:
        assert property (st && !cfg[0] |-> !pcm_clk_oe_o && !pcm_sync_oe_o)
        else $error("slave drives clock or sync");
    AST_MASTER_DRIVES:
        assert property (st && me |-> pcm_clk_oe_o && pcm_sync_oe_o)
        else $error("master not driving clock and sync");
    AST_IDLE_QUIET:
        assert property (st && (!cfg[1] || cfg[9:6] == 4'h0) |->
            !pcm_out_oe_o)
        else $error("data driven with no active slot");
    AST_MUTE_ZERO:
        assert property (st && cfg[16] && pcm_out_oe_o |-> !pcm_out_o)
        else $error("muted output not zero");
    AST_SYNC_HELD:
        assert property (st && me && cfg[17] |-> !pcm_sync_o)
        else $error("sync not held low");
    AST_HALF_PERIOD:
        assert property (st && me && tv && tog |->
            hc + 10'h002 >= h && hc <= h)
        else $error("bit clock half period wrong");
    AST_LONG_SYNC:
        assert property ($fell(pcm_sync_o) && sv && me &&
            cfg[3:2] == 2'h0 |-> sh + 13'h0003 >= lw && sh <= lw + 13'h0003)
        else $error("long sync width wrong");
endmodule
bind pvp_voice_port pvp_voice_port_asserts u_chk (.*);
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the voice serial port
`timescale 1ns/1ps
`default_nettype none
`include "pvp_defines.svh"
module tb import pvp_pkg::*;;
    logic clk_i = 1'h0, rst_i = 1'h1, run = 1'h0, shrt = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, f_rx;
    logic wb_ack_o, pcm_clk_o, pcm_clk_oe_o, pcm_sync_o, pcm_sync_oe_o;
    logic pcm_out_o, pcm_out_oe_o, f_clk, f_sync, f_din;
    logic [15:0] pat = 16'h0;
    logic [15:0] tx [4];
    int miscompares = 0, compares = 0, cyc = 0;
    // pins resolved from whoever owns them
    wire pcm_clk_i = pcm_clk_oe_o ? pcm_clk_o : f_clk;
    wire pcm_sync_i = pcm_sync_oe_o ? pcm_sync_o : f_sync;
    wire pcm_in_i = f_din;
    pvp_voice_port u_dut (.*);
    pvp_far_end u_far (.run_i(run), .short_i(shrt), .clk_w_i(pcm_clk_i),
        .sync_w_i(pcm_sync_i), .out_i(pcm_out_o), .oe_i(pcm_out_oe_o),
        .pat_i(pat), .bclk_o(f_clk), .sync_o(f_sync), .din_o(f_din),
        .rx_o(f_rx));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, well above the expected run length
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one classic cycle; only the hang guard ends the wait for ack
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        chk({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    function automatic logic [31:0] cf(input logic m, input pvp_frame_e fr,
        input pvp_fmt_e f, input logic [3:0] k, input logic s16,
        input logic mu, input logic z, input logic [1:0] r);
        return {12'h0, r, z, mu, 3'h5, PVP_FILL_SIGN, s16, k, f, fr,
            1'h1, m};
    endfunction
    // enable a mode, let it run, then switch the port off
    task automatic mode(input logic [31:0] c, input int n);
        wb(1'h1, `PVP_ADDR_CFG, c, 4'hF);
        repeat (n) @(posedge clk_i);
        run <= 1'h0;
        repeat (700) @(posedge clk_i);
        wb(1'h1, `PVP_ADDR_CFG, 32'h0, 4'hF);
    endtask
    initial begin
        void'($urandom(32'h03df3f2e));
        for (int i = 0; i < 4; i++)
            tx[i] = 16'($urandom);
        pat = 16'($urandom);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wb(1'h0, `PVP_ADDR_CFG, 32'h0, 4'hF);
        chk(q, `PVP_CFG_RESET);
        wb(1'h1, 8'hC0, 32'hFFFF_FFFF, 4'hF);
        wb(1'h0, 8'hC0, 32'h0, 4'hF);
        chk(q, 32'h0);
        wb(1'h1, `PVP_ADDR_CFG, 32'hFFFF_FFFF, 4'h0);
        wb(1'h0, `PVP_ADDR_CFG, 32'h0, 4'hF);
        chk(q, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wb(1'h1, 8'h10 + 8'(4 * i), {16'h0, tx[i]}, 4'hF);
            wb(1'h0, 8'h10 + 8'(4 * i), 32'h0, 4'hF);
            chk(q, {16'h0, tx[i]});
        end
        // master long sync, 8-bit slot 0 at the slowest clock
        mode(cf(1'h1, PVP_LONG, PVP_ULAW, 4'h1, 1'h0, 1'h0, 1'h0, 2'h0),
            8300);
        chk({24'h0, f_rx[7:0]}, {24'h0, tx[0][7:0]});
        wb(1'h0, 8'h20, 32'h0, 4'hF);
        chk({24'h0, q[7:0]}, {24'h0, pat[15:8]});
        // 8-bit sample in a 16-clock slot, attenuation fill, late release
        mode(cf(1'h1, PVP_LONG, PVP_ULAW, 4'h1, 1'h1, 1'h0, 1'h0, 2'h2) |
            32'h0010_1000, 3500);
        chk({16'h0, f_rx[15:0]}, {16'h0, tx[0][7:0], 5'h00, 3'h5});
        wb(1'h0, 8'h20, 32'h0, 4'hF);
        chk(q, {24'h0, pat[15:8]});
        // master short sync, 13-bit sign filled in 16-clock slot 1
        // the first short frame only starts after a full frame of bits
        shrt <= 1'h1;
        mode(cf(1'h1, PVP_SHORT, PVP_LIN13, 4'h2, 1'h1, 1'h0, 1'h0, 2'h2),
            19200);
        chk({16'h0, f_rx[15:0]}, {16'h0, {3{tx[1][12]}}, tx[1][12:0]});
        wb(1'h0, 8'h24, 32'h0, 4'hF);
        chk({16'h0, q[15:0]}, {16'h0, {3{pat[12]}}, pat[12:0]});
        // slave long sync, fast far clock, two 16-bit slots
        shrt <= 1'h0;
        run <= 1'h1;
        mode(cf(1'h0, PVP_LONG, PVP_LIN16, 4'h3, 1'h1, 1'h0, 1'h0, 2'h0),
            2000);
        chk(f_rx, {tx[0], tx[1]});
        wb(1'h0, 8'h24, 32'h0, 4'hF);
        chk({16'h0, q[15:0]}, {16'h0, pat});
        // gci framing, muted a-law in slot 2
        mode(cf(1'h1, PVP_GCI, PVP_ALAW, 4'h4, 1'h0, 1'h1, 1'h0, 2'h2),
            8300);
        chk({24'h0, f_rx[7:0]}, 32'h0);
        wb(1'h0, 8'h28, 32'h0, 4'hF);
        chk({24'h0, q[7:0]}, {24'h0, pat[15:8]});
        // sync held low, clock still running, no slots
        wb(1'h1, `PVP_ADDR_CFG,
            cf(1'h1, PVP_LONG, PVP_LIN16, 4'h0, 1'h1, 1'h0, 1'h1, 2'h1),
            4'hF);
        repeat (3000) @(posedge clk_i);
        chk({31'h0, pcm_clk_oe_o}, 32'h1);
        chk({30'h0, pcm_sync_oe_o, pcm_sync_o}, 32'h2);
        wrap_up();
    end
endmodule
`default_nettype wire
